// ---- include/sram_map.vh ----
`ifndef SRAM_MAP_VH
`define SRAM_MAP_VH

// Pin widths of the 1024 x 4 part
`define SRAM_ADDR_W       10
`define SRAM_DATA_W       4

// Clock period in picoseconds (200 MHz)
`define SRAM_CLK_PS       5000

// Device timing in nanoseconds
`define SRAM_T_AA_NS      70
`define SRAM_T_WP_NS      50
`define SRAM_T_DW_NS      25
`define SRAM_T_WC_NS      70
`define SRAM_T_WR_NS      5
`define SRAM_T_HZ_NS      20

// Stages of the read data synchroniser
`define SRAM_SYNC_STAGES  2

// Width of the phase timer
`define SRAM_TMR_W        8

// Controller states
`define SRAM_ST_IDLE      3'h0
`define SRAM_ST_READ      3'h1
`define SRAM_ST_WRITE     3'h2
`define SRAM_ST_RECOV     3'h3
`define SRAM_ST_TURN      3'h4

`endif

// ---- hw/sram_tmr.v ----
`timescale 1ns/100ps
`include "sram_map.vh"

module sram_tmr #(
   parameter W = `SRAM_TMR_W
) (
   input  wire         ref_clk,   // System clock
   input  wire         rst,       // Asynchronous reset, active high
   input  wire         load,      // Load a new count
   input  wire [W-1:0] value,     // Count to load
   output wire         done       // Count has reached zero
);

   reg [W-1:0] cnt;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= {W{1'b0}};
      end else if (load) begin
         cnt <= value;
      end else if (cnt != {W{1'b0}}) begin
         cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (cnt == {W{1'b0}});

endmodule // sram_tmr

// ---- hw/sram_ctrl.v ----
`timescale 1ns/100ps
`include "sram_map.vh"

// Operation
// (RULE1) The array holds 1024 words of four bits each, chosen by a ten-bit word index.
// (RULE2) A read does not alter the word, and the word seen on the data pins has the polarity that was written.
// (RULE3) The device needs no clock or refresh and acts only on the levels of its address and control pins.
// (RULE4) The device needs no address setup, so the write strobe may fall together with the new address.
// (RULE5) The four data pins are shared: the device drives them only in reads, the controller only in writes.
// (RULE6) While not selected the device holds its data outputs in high impedance.
// (RULE7) With chip select high the device sits in standby and resumes on reselection.
// (RULE8) The controller holds write enable high through every read.
// (RULE9) If chip select rises while write enable is high, the device outputs stay in high impedance.
// (RULE10) For a read started by chip select, the address is valid no later than chip select falls.
// (RULE11) Held selected with write enable high, the device outputs follow each new address with no strobe.
// (RULE12) While write enable is low the device releases its outputs and drives again only after the write.
// (RULE13) The read cycle equals the access time, so reads may follow back to back at the access rate.
// (RULE14) A write happens in the overlap of select and write enable low, takes the data at its end, and needs a stable address.

module sram_ctrl #(
   parameter AW      = `SRAM_ADDR_W,
   parameter DW      = `SRAM_DATA_W,
   parameter T_AA_NS = `SRAM_T_AA_NS,
   parameter T_WP_NS = `SRAM_T_WP_NS,
   parameter T_DW_NS = `SRAM_T_DW_NS,
   parameter T_WC_NS = `SRAM_T_WC_NS,
   parameter T_WR_NS = `SRAM_T_WR_NS,
   parameter T_HZ_NS = `SRAM_T_HZ_NS
) (
   input  wire          ref_clk,        // System clock, 200 MHz
   input  wire          rst,            // Asynchronous reset, active high
   input  wire          req,            // Request valid
   input  wire          req_we,         // 1 write, 0 read
   input  wire [AW-1:0] req_addr,       // Word to access
   input  wire [DW-1:0] req_wdata,      // Write data
   output wire          ready,          // Request taken when high with req
   output reg  [DW-1:0] rdata,          // Read data
   output reg           rvalid,         // Read data valid, one cycle
   output reg           wdone,          // Write finished, one cycle
   output reg  [AW-1:0] word_index,     // Address pins
   output reg           chip_sel_n,     // Chip select, active low
   output reg           write_en_n,     // Write enable, active low
   input  wire [DW-1:0] shared_data_in, // Data pins as seen on the wire
   output reg  [DW-1:0] shared_data_out,// Data driven onto the pins
   output reg           shared_data_oe  // High while the controller drives
);

   ////////////////////////////////////////////////////////////////////////////
   // Timing counts

   // Minimum times round up to whole cycles, never below one
   function [`SRAM_TMR_W-1:0] ns_to_cyc;
      input integer ns;
      integer c;
      begin
         c = (ns * 1000 + `SRAM_CLK_PS - 1) / `SRAM_CLK_PS;
         if (c < 1) c = 1;
         ns_to_cyc = c[`SRAM_TMR_W-1:0];
      end
   endfunction

   localparam [`SRAM_TMR_W-1:0] ONE     = {{(`SRAM_TMR_W-1){1'b0}}, 1'b1};
   localparam integer           SYNC_N  = `SRAM_SYNC_STAGES;
   localparam [`SRAM_TMR_W-1:0] SYNC_C  = SYNC_N[`SRAM_TMR_W-1:0];
   // Read phase covers the access time plus the synchroniser delay
   localparam [`SRAM_TMR_W-1:0] RD_CYC  = ns_to_cyc(T_AA_NS) + SYNC_C;
   // Overlap must meet both pulse width and data setup
   localparam [`SRAM_TMR_W-1:0] WP_CYC  = (ns_to_cyc(T_WP_NS) > ns_to_cyc(T_DW_NS)) ?
                                          ns_to_cyc(T_WP_NS) : ns_to_cyc(T_DW_NS);
   localparam [`SRAM_TMR_W-1:0] WR_MIN  = ns_to_cyc(T_WR_NS);
   localparam [`SRAM_TMR_W-1:0] WC_REST = (ns_to_cyc(T_WC_NS) > WP_CYC) ?
                                          ns_to_cyc(T_WC_NS) - WP_CYC : ONE;
   localparam [`SRAM_TMR_W-1:0] WR_CYC  = (WC_REST > WR_MIN) ? WC_REST : WR_MIN;
   localparam [`SRAM_TMR_W-1:0] HZ_CYC  = ns_to_cyc(T_HZ_NS);

   ////////////////////////////////////////////////////////////////////////////
   // Read data synchroniser

   reg [DW-1:0] sync1;
   reg [DW-1:0] sync2;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1 <= {DW{1'b0}};
         sync2 <= {DW{1'b0}};
      end else begin
         sync1 <= shared_data_in;
         sync2 <= sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   reg  [2:0]             state;
   reg  [2:0]             next_state;
   reg                    tmr_load;
   reg  [`SRAM_TMR_W-1:0] tmr_value;
   wire                   tmr_done;

   sram_tmr #(
      .W     (`SRAM_TMR_W)
   ) u_tmr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (tmr_load),
      .value   (tmr_value),
      .done    (tmr_done)
   );

   // A read may chain straight into the next read without deselecting;
   // a write behind a read is held off until idle, so it is never taken and lost
   assign ready = (state == `SRAM_ST_IDLE) || ((state == `SRAM_ST_READ) && tmr_done && !req_we); // RULE13
   wire take = req && ready;

   always @* begin
      next_state = state;
      tmr_load   = 1'b0;
      tmr_value  = {`SRAM_TMR_W{1'b0}};
      case (state)
         `SRAM_ST_IDLE: begin
            if (take && req_we) begin
               next_state = `SRAM_ST_WRITE;
               tmr_load   = 1'b1;
               tmr_value  = WP_CYC - ONE;
            end else if (take) begin
               next_state = `SRAM_ST_READ;
               tmr_load   = 1'b1;
               tmr_value  = RD_CYC - ONE;
            end
         end
         `SRAM_ST_READ: begin
            if (tmr_done) begin
               if (take && !req_we) begin
                  next_state = `SRAM_ST_READ; // RULE11
                  tmr_load   = 1'b1;
                  tmr_value  = RD_CYC - ONE;
               end else begin
                  // Let the device outputs float before anyone drives the bus
                  next_state = `SRAM_ST_TURN; // RULE12
                  tmr_load   = 1'b1;
                  tmr_value  = HZ_CYC - ONE;
               end
            end
         end
         `SRAM_ST_WRITE: begin
            if (tmr_done) begin
               next_state = `SRAM_ST_RECOV;
               tmr_load   = 1'b1;
               tmr_value  = WR_CYC - ONE;
            end
         end
         `SRAM_ST_RECOV: begin
            if (tmr_done) next_state = `SRAM_ST_IDLE;
         end
         `SRAM_ST_TURN: begin
            if (tmr_done) next_state = `SRAM_ST_IDLE;
         end
         default: begin
            next_state = `SRAM_ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin and user registers

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state           <= `SRAM_ST_IDLE;
         rdata           <= {DW{1'b0}};
         rvalid          <= 1'b0;
         wdone           <= 1'b0;
         word_index      <= {AW{1'b0}};
         chip_sel_n      <= 1'b1;
         write_en_n      <= 1'b1;
         shared_data_out <= {DW{1'b0}};
         shared_data_oe  <= 1'b0;
      end else begin
         state  <= next_state;
         rvalid <= 1'b0;
         wdone  <= 1'b0;
         if (take) begin
            // Address moves on the edge that selects the chip, or with the chip held selected for a chained read
            word_index <= req_addr[AW-1:0]; // RULE1 RULE10 RULE4
         end
         case (next_state)
            `SRAM_ST_READ: begin
               chip_sel_n     <= 1'b0;
               write_en_n     <= 1'b1; // RULE8
               shared_data_oe <= 1'b0; // RULE5
            end
            `SRAM_ST_WRITE: begin
               chip_sel_n     <= 1'b0; // RULE14
               write_en_n     <= 1'b0; // RULE4
               shared_data_oe <= 1'b1; // RULE5
               if (take) shared_data_out <= req_wdata;
            end
            `SRAM_ST_RECOV: begin
               // Both strobes rise together; address and data held past the end
               chip_sel_n <= 1'b1; // RULE14
               write_en_n <= 1'b1;
            end
            default: begin
               // Deselected while idle puts the device in standby
               chip_sel_n     <= 1'b1; // RULE7 RULE9
               write_en_n     <= 1'b1;
               shared_data_oe <= 1'b0; // RULE6
            end
         endcase
         if ((state == `SRAM_ST_READ) && tmr_done) begin
            rdata  <= sync2; // RULE2
            rvalid <= 1'b1;
         end
         if ((state == `SRAM_ST_RECOV) && tmr_done) begin
            wdone <= 1'b1;
         end
         // No refresh is ever issued; the idle state may last forever (RULE3)
      end
   end

endmodule // sram_ctrl

// ---- bench/sram_ctrl_asserts.sv ----
`timescale 1ns/100ps
module sram_ctrl_asserts #(
   parameter AW = 10,
   parameter DW = 4
) (
   input wire logic          ref_clk,         // Clock
   input wire logic          rst,             // Reset
   input wire logic          req,             // Request
   input wire logic          req_we,          // Write
   input wire logic          ready,           // Taken
   input wire logic          rvalid,          // Read done
   input wire logic          wdone,           // Write done
   input wire logic [AW-1:0] word_index,      // Address
   input wire logic          chip_sel_n,      // Select
   input wire logic          write_en_n,      // Strobe
   input wire logic [DW-1:0] shared_data_out, // Drive value
   input wire logic          shared_data_oe   // Drive enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_overlap;
      !write_en_n [*8] ##1 !write_en_n [*2] ##1 write_en_n;
   endsequence
   sequence s_oe_tail;
      shared_data_oe [*4] ##1 !shared_data_oe;
   endsequence
   a_no_drive_read: assert property (!chip_sel_n && write_en_n |-> !shared_data_oe)
      else $error("pins driven in read");
   a_we_high_read: assert property ($fell(chip_sel_n) && write_en_n |-> write_en_n [*8])
      else $error("strobe in read");
   a_addr_read: assert property ($fell(chip_sel_n) && write_en_n |=> $stable(word_index) [*8])
      else $error("address moved in read");
   a_addr_write: assert property (!chip_sel_n && !write_en_n && !$past(chip_sel_n) && !$past(write_en_n)
      |-> $stable(word_index) && $stable(shared_data_out)) else $error("address moved in write");
   a_write_overlap: assert property ($fell(write_en_n) |-> s_overlap)
      else $error("write overlap length");
   a_data_hold: assert property ($rose(write_en_n) |-> s_oe_tail)
      else $error("data hold length");
   a_strobe_addr: assert property ($fell(write_en_n) |-> $fell(chip_sel_n) && $rose(shared_data_oe))
      else $error("strobe not with address");
   a_write_done: assert property (req && ready && req_we && chip_sel_n |-> ##15 wdone)
      else $error("write end late");
   a_read_done: assert property (req && ready && !req_we |-> ##17 rvalid)
      else $error("read end late");
endmodule // sram_ctrl_asserts

bind sram_ctrl sram_ctrl_asserts #(.AW(AW), .DW(DW)) i_sram_ctrl_asserts (.ref_clk(ref_clk), .rst(rst),
   .req(req), .req_we(req_we), .ready(ready), .rvalid(rvalid), .wdone(wdone), .word_index(word_index),
   .chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .shared_data_out(shared_data_out),
   .shared_data_oe(shared_data_oe));

// ---- bench/sram_mem_model.sv ----
`timescale 1ns/100ps
// Level-driven array with no clock or refresh
module sram_mem_model #(
   parameter T_ACC_NS = 65
) (
   input  wire logic [9:0] word_index, // Address
   input  wire logic       chip_sel_n, // Select
   input  wire logic       write_en_n, // Strobe
   input  wire logic [3:0] data_in,    // Wire level
   output wire logic [3:0] data_out,   // Read value
   output wire logic       data_oe     // Drives pins
);
   logic [3:0]  cells [0:1023];
   logic        in_wr = 1'b0;
   wire         rd_sel = !chip_sel_n && write_en_n;
   wire         wr_end = chip_sel_n | write_en_n;
   wire  [10:0] key = {word_index, rd_sel};
   wire  [10:0] key_late;
   // Inertial delay: settles one access after the last change, so early samples see junk
   assign #(T_ACC_NS) key_late = key;
   assign data_oe = rd_sel;
   assign data_out = (key_late === key) ? cells[word_index] : ~cells[word_index];
   always @(wr_end) begin
      if (wr_end === 1'b0) begin
         in_wr = 1'b1;
      end else if (wr_end === 1'b1) begin
         if (in_wr) begin
            cells[word_index] = data_in;
         end
         in_wr = 1'b0;
      end
   end
endmodule // sram_mem_model

// ---- bench/tb_sram_ctrl.sv ----
`timescale 1ns/100ps
module tb_sram_ctrl;
   logic       ref_clk = 0;
   logic       rst = 1;
   logic       req = 0;
   logic       req_we = 0;
   logic [9:0] req_addr = 10'h000;
   logic [3:0] req_wdata = 4'h0;
   logic [3:0] last_bus = 4'h0;
   logic [3:0] q;
   int         miscompares = 0;
   int         compares = 0;
   int         cyc = 0;
   wire        ready, rvalid, wdone, chip_sel_n, write_en_n, ctrl_oe, mem_oe;
   wire  [3:0] rdata, ctrl_out, mem_q, bus;
   wire  [9:0] word_index;
   // Nobody driving: pins show the inverse of the last driven level
   assign bus = ctrl_oe ? ctrl_out : mem_oe ? mem_q : ~last_bus;
   sram_ctrl i_sram_ctrl (.ref_clk(ref_clk), .rst(rst), .req(req), .req_we(req_we), .req_addr(req_addr),
      .req_wdata(req_wdata), .ready(ready), .rdata(rdata), .rvalid(rvalid), .wdone(wdone),
      .word_index(word_index), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .shared_data_in(bus),
      .shared_data_out(ctrl_out), .shared_data_oe(ctrl_oe));
   sram_mem_model i_sram_mem_model (.word_index(word_index), .chip_sel_n(chip_sel_n),
      .write_en_n(write_en_n), .data_in(bus), .data_out(mem_q), .data_oe(mem_oe));
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (ctrl_oe | mem_oe) last_bus <= bus;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_ready;
      int n = 0;
      do @(negedge ref_clk); while (ready !== 1'b1 && ++n < 40);
      chk("ready", 16'(ready), 16'h0001);
   endtask
   task automatic xfer(input logic we, input logic [9:0] a, input logic [3:0] d);
      int n = 0;
      @(posedge ref_clk);
      req <= 1'b1;
      req_we <= we;
      req_addr <= a;
      req_wdata <= d;
      wait_ready;
      @(posedge ref_clk);
      req <= 1'b0;
      do @(negedge ref_clk); while ((we ? wdone : rvalid) !== 1'b1 && ++n < 40);
      chk("answer", 16'(n < 40), 16'h0001);
      q = rdata;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_corners;
      logic [9:0] ad [3] = '{10'h000, 10'h3FF, 10'h155};
      logic [3:0] dd [3] = '{4'hF, 4'h0, 4'hA};
      for (int i = 0; i < 3; i++) xfer(1'b1, ad[i], dd[i]);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, ad[i % 3], 4'h0);
         chk("rdata", 16'(q), 16'(dd[i % 3]));
      end
      chk("standby", 16'(chip_sel_n), 16'h0001);
      $display("test corners done");
   endtask
   task automatic t_b2b;
      int c0;
      logic early = 1'b0;
      @(posedge ref_clk);
      req <= 1'b1;
      req_we <= 1'b0;
      req_addr <= 10'h3FF;
      wait_ready;
      @(posedge ref_clk);
      req_addr <= 10'h155;
      wait_ready;
      @(posedge ref_clk);
      // A write queued behind the chained read must wait for idle
      req_we <= 1'b1;
      req_addr <= 10'h2AA;
      req_wdata <= 4'h5;
      @(negedge ref_clk);
      c0 = cyc;
      chk("first", {rvalid, 11'h000, rdata}, 16'h8000);
      chk("held select", 16'(chip_sel_n), 16'h0000);
      for (int n = 0; n < 40 && rvalid !== 1'b1 || n == 0; n++) begin
         @(negedge ref_clk);
         early = early | ready;
      end
      chk("second", 16'(rdata), 16'h000A);
      chk("spacing", 16'(cyc - c0), 16'd16);
      chk("write held off", 16'(early), 16'h0000);
      wait_ready;
      @(posedge ref_clk);
      req <= 1'b0;
      xfer(1'b0, 10'h2AA, 4'h0);
      chk("queued write", 16'(q), 16'h0005);
      $display("test back to back done");
   endtask
   task automatic t_overwrite;
      xfer(1'b1, 10'h0AA, 4'h3);
      xfer(1'b1, 10'h0AA, 4'hC);
      xfer(1'b0, 10'h0AA, 4'h0);
      chk("last write", 16'(q), 16'h000C);
      xfer(1'b0, 10'h000, 4'h0);
      chk("neighbour", 16'(q), 16'h000F);
      $display("test overwrite done");
   endtask
   task tally_and_finish;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk("reset pins", {chip_sel_n, write_en_n, ctrl_oe}, 16'h0006);
      $display("test reset done");
      t_corners;
      t_b2b;
      t_overwrite;
      tally_and_finish;
   end
   // Tests need about 400 cycles; allow ten times that
   initial begin
      #20000;
      miscompares++;
      tally_and_finish;
   end
endmodule // tb_sram_ctrl
